// ==== inc/conv_ctl_defines.svh ====
// register indices, field positions, reset values and command codes of the converter control block
`ifndef CONV_CTL_DEFINES_SVH
`define CONV_CTL_DEFINES_SVH

// ======================================================
// register indices (byte address is four times the index)
`define IDX_CONTROL_A 6'h00
`define IDX_CONTROL_B_PRESCALE 6'h01
`define IDX_CONTROL_C_REFERENCE 6'h02
`define IDX_CONTROL_D_WINDOW 6'h03
`define IDX_IRQ_ENABLE 6'h04
`define IDX_IRQ_FLAG 6'h05
`define IDX_STATUS 6'h06
`define IDX_DEBUG_CONTROL 6'h07
`define IDX_CONTROL_E_SAMPLE_TIME 6'h08
`define IDX_CONTROL_F_ACCUMULATE 6'h09
`define IDX_COMMAND 6'h0a
`define IDX_GAIN_AMP_CONTROL 6'h0b
`define IDX_POSITIVE_INPUT_SELECT 6'h0c
`define IDX_NEGATIVE_INPUT_SELECT 6'h0d
`define IDX_RESULT 6'h10
`define IDX_SAMPLE 6'h14
`define IDX_TEMP_BYTE_0 6'h18
`define IDX_TEMP_BYTE_1 6'h19
`define IDX_TEMP_BYTE_2 6'h1a
`define IDX_WINDOW_LOW_THRESHOLD 6'h1c
`define IDX_WINDOW_HIGH_THRESHOLD 6'h1e

// ======================================================
// field positions
`define BIT_STANDBY_RUN_ENABLE 7
`define BIT_ANALOG_KEEP_ON 5
`define BIT_CONVERTER_ENABLE 0
`define BIT_WINDOW_SOURCE_SELECT 3
`define BIT_TRIGGER_OVERRUN 5
`define BIT_SAMPLE_OVERWRITE 4
`define BIT_RESULT_OVERWRITE 3
`define BIT_WINDOW_MATCH 2
`define BIT_SAMPLE_READY 1
`define BIT_RESULT_READY 0
`define BIT_BUSY 0
`define BIT_RUN_WHILE_HALTED 0

// ======================================================
// reset values and masks
`define RESET_BYTE 8'h00
`define MASK_CONTROL_A 8'ha1
`define MASK_IRQ 8'h3f
`define MASK_CONTROL_D 8'h0f

// ======================================================
// start command codes
`define START_STOP 3'h0
`define START_IMMEDIATE 3'h1
`define START_EVENT_TRIGGER 3'h2

`endif

// ==== inc/conv_ctl_pkg.sv ====
// types shared by the converter control block
package conv_ctl_pkg;
  typedef enum logic [2:0] {
    win_none,
    win_below,
    win_above,
    win_inside,
    win_outside
  } win_mode_type;
  typedef enum {
    st_idle,
    st_converting
  } conv_state_type;
  typedef logic [31:0] apb_word_type;
endpackage

// ==== core/adc_irq_sleep_debug_regs.sv ====
// converter control shell: registers, interrupt flags, sleep and debug gating
// Notes on behaviour
// - trigger during conversion sets overrun, error vector
// - unread sample overwritten sets sample overwrite
// - unread result overwritten sets result overwrite
// - new sample sets sample ready flag
// - new result sets result ready flag
// - window match routed by source, per mode
// - flags set regardless of enable bits
// - each source enabled by its enable bit
// - request while enable and flag both set
// - conversion finishes before idle or standby
// - idle sleep still starts event-triggered conversions
// - standby starts event conversions only if enabled
// - keep-on plus standby run keeps analog powered
// - power-down aborts conversion at once
// - run-while-halted set keeps normal operation
// - halted without it: finish, then halt
// - control A bits 7, 5, 0, reset zero
// - standby run clear: finish then sleep
// - window modes: none, below, above, inside, outside
// - window source: result low half or sample
// - keep-on holds analog on, else per conversion
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "conv_ctl_defines.svh"

module adc_irq_sleep_debug_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output conv_ctl_pkg::apb_word_type prdata,
  output logic pready,
  output logic pslverr,
  // system state
  input wire logic sleep_idle,
  input wire logic sleep_standby,
  input wire logic sleep_powerdown,
  input wire logic debug_halt,
  // start event from the event system
  input wire logic start_event,
  // converter core
  input wire logic conv_sample_done,
  input wire logic [15:0] conv_sample_data,
  input wire logic conv_result_done,
  input wire logic [31:0] conv_result_data,
  output logic conv_start,
  output logic conv_abort,
  output logic analog_power_on,
  // interrupt requests
  output logic irq_error,
  output logic irq_sample_ready,
  output logic irq_result_ready
);
  import conv_ctl_pkg::*;

  // ======================================================
  // register storage
  logic [7:0] control_a_r;
  logic [7:0] control_b_prescale_r;
  logic [7:0] control_c_reference_r;
  logic [7:0] control_d_window_r;
  logic [7:0] irq_enable_r;
  logic [7:0] irq_flag_r;
  logic [7:0] debug_control_r;
  logic [7:0] control_e_sample_time_r;
  logic [7:0] control_f_accumulate_r;
  logic [7:0] command_r;
  logic [7:0] gain_amp_control_r;
  logic [7:0] positive_input_select_r;
  logic [7:0] negative_input_select_r;
  logic [7:0] temp_byte_r [3];
  logic [15:0] window_low_threshold_r;
  logic [15:0] window_high_threshold_r;
  logic [31:0] result_r;
  logic [15:0] sample_r;
  logic sample_unread_r;
  logic result_unread_r;
  conv_state_type state_r;
  logic event_meta_r;
  logic event_sync_r;
  logic event_prev_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // ======================================================
  // decode
  logic [5:0] idx;
  logic setup_phase;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [7:0] wbyte;

  assign idx = paddr[7:2];
  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign wbyte = pwdata[7:0];

  always_comb begin
    unique case (idx)
      `IDX_CONTROL_A, `IDX_CONTROL_B_PRESCALE, `IDX_CONTROL_C_REFERENCE,
      `IDX_CONTROL_D_WINDOW, `IDX_IRQ_ENABLE, `IDX_IRQ_FLAG, `IDX_STATUS,
      `IDX_DEBUG_CONTROL, `IDX_CONTROL_E_SAMPLE_TIME, `IDX_CONTROL_F_ACCUMULATE,
      `IDX_COMMAND, `IDX_GAIN_AMP_CONTROL, `IDX_POSITIVE_INPUT_SELECT,
      `IDX_NEGATIVE_INPUT_SELECT, `IDX_RESULT, `IDX_SAMPLE, `IDX_TEMP_BYTE_0,
      `IDX_TEMP_BYTE_1, `IDX_TEMP_BYTE_2, `IDX_WINDOW_LOW_THRESHOLD,
      `IDX_WINDOW_HIGH_THRESHOLD: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ======================================================
  // control fields
  logic converter_enable;
  logic analog_keep_on;
  logic standby_run_enable;
  logic run_while_halted;
  logic window_source_select;
  logic [2:0] window_compare_mode;
  logic [2:0] start_mode;

  assign converter_enable = control_a_r[`BIT_CONVERTER_ENABLE];
  assign analog_keep_on = control_a_r[`BIT_ANALOG_KEEP_ON];
  assign standby_run_enable = control_a_r[`BIT_STANDBY_RUN_ENABLE];
  assign run_while_halted = debug_control_r[`BIT_RUN_WHILE_HALTED];
  assign window_source_select = control_d_window_r[`BIT_WINDOW_SOURCE_SELECT];
  assign window_compare_mode = control_d_window_r[2:0];
  assign start_mode = command_r[2:0];

  // ======================================================
  // start event synchroniser and edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_meta_r <= 1'b0;
      event_sync_r <= 1'b0;
      event_prev_r <= 1'b0;
    end else begin
      event_meta_r <= start_event;
      event_sync_r <= event_meta_r;
      event_prev_r <= event_sync_r;
    end
  end

  // ======================================================
  // sleep and debug gating
  logic halted;
  logic standby_blocked;
  logic event_trig;
  logic sw_trig;
  logic trig;
  logic start_ok;
  logic busy;

  assign busy = (state_r == st_converting);
  assign halted = debug_halt && !run_while_halted;
  assign standby_blocked = sleep_standby && !standby_run_enable;
  assign event_trig = event_sync_r && !event_prev_r && (start_mode == `START_EVENT_TRIGGER);
  assign sw_trig = wr_en && (idx == `IDX_COMMAND) && (wbyte[2:0] == `START_IMMEDIATE);
  // idle and standby admit only event triggers
  assign trig = converter_enable && !sleep_powerdown && !halted && !standby_blocked
    && (event_trig || (sw_trig && !sleep_idle && !sleep_standby));
  assign start_ok = trig && !busy;

  // ======================================================
  // conversion state: a started conversion runs to its end unless power-down or converter enable cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= st_idle;
    end else begin
      unique case (state_r)
        st_idle: begin
          if (start_ok) begin
            state_r <= st_converting;
          end
        end
        st_converting: begin
          if (sleep_powerdown || !converter_enable) begin
            state_r <= st_idle;
          end else if (conv_result_done) begin
            state_r <= st_idle;
          end
        end
      endcase
    end
  end

  assign conv_start = start_ok;
  assign conv_abort = busy && (sleep_powerdown || !converter_enable);

  // analog modules stay on with keep-on while the block may run
  assign analog_power_on = busy || (converter_enable && analog_keep_on && !sleep_powerdown
    && !halted && !standby_blocked);

  // ======================================================
  // data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_r <= 16'h0000;
    end else if (conv_sample_done && busy) begin
      sample_r <= conv_sample_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= 32'h0000_0000;
    end else if (conv_result_done && busy) begin
      result_r <= conv_result_data;
    end
  end

  logic sample_new;
  logic result_new;
  logic sample_read;
  logic result_read;

  assign sample_new = conv_sample_done && busy;
  assign result_new = conv_result_done && busy;
  assign sample_read = rd_en && (idx == `IDX_SAMPLE);
  assign result_read = rd_en && (idx == `IDX_RESULT);

  // a new value counts as unread even if read in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_unread_r <= 1'b0;
      result_unread_r <= 1'b0;
    end else begin
      if (sample_new) begin
        sample_unread_r <= 1'b1;
      end else if (sample_read) begin
        sample_unread_r <= 1'b0;
      end
      if (result_new) begin
        result_unread_r <= 1'b1;
      end else if (result_read) begin
        result_unread_r <= 1'b0;
      end
    end
  end

  // ======================================================
  // window comparator
  logic [15:0] win_operand;
  logic win_hit;
  logic win_check;

  assign win_operand = window_source_select ? conv_sample_data : conv_result_data[15:0];
  assign win_check = window_source_select ? sample_new : result_new;

  always_comb begin
    win_hit = 1'b0;
    unique case (window_compare_mode)
      win_below: win_hit = win_operand < window_low_threshold_r;
      win_above: win_hit = win_operand > window_high_threshold_r;
      win_inside: win_hit = (win_operand > window_low_threshold_r) && (win_operand < window_high_threshold_r);
      win_outside: win_hit = (win_operand < window_low_threshold_r) || (win_operand > window_high_threshold_r);
      default: win_hit = 1'b0;
    endcase
  end

  // ======================================================
  // interrupt flags: hardware set wins over software clear
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb begin
    flag_set = 8'h00;
    flag_set[`BIT_TRIGGER_OVERRUN] = trig && busy;
    flag_set[`BIT_SAMPLE_OVERWRITE] = sample_new && sample_unread_r;
    flag_set[`BIT_RESULT_OVERWRITE] = result_new && result_unread_r;
    flag_set[`BIT_SAMPLE_READY] = sample_new;
    flag_set[`BIT_RESULT_READY] = result_new;
    flag_set[`BIT_WINDOW_MATCH] = win_check && win_hit;
  end

  assign flag_clr = (wr_en && (idx == `IDX_IRQ_FLAG)) ? (wbyte & `MASK_IRQ) : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_r <= `RESET_BYTE;
    end else begin
      irq_flag_r <= (irq_flag_r & ~flag_clr) | flag_set;
    end
  end

  // ======================================================
  // request vectors
  logic [7:0] pending;

  assign pending = irq_flag_r & irq_enable_r;
  assign irq_error = pending[`BIT_TRIGGER_OVERRUN] || pending[`BIT_SAMPLE_OVERWRITE]
    || pending[`BIT_RESULT_OVERWRITE];
  assign irq_sample_ready = pending[`BIT_SAMPLE_READY]
    || (pending[`BIT_WINDOW_MATCH] && window_source_select);
  assign irq_result_ready = pending[`BIT_RESULT_READY]
    || (pending[`BIT_WINDOW_MATCH] && !window_source_select);

  // ======================================================
  // software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_a_r <= `RESET_BYTE;
      control_d_window_r <= `RESET_BYTE;
      irq_enable_r <= `RESET_BYTE;
      debug_control_r <= `RESET_BYTE;
      command_r <= `RESET_BYTE;
    end else if (wr_en) begin
      unique case (idx)
        `IDX_CONTROL_A: control_a_r <= wbyte & `MASK_CONTROL_A;
        `IDX_CONTROL_D_WINDOW: control_d_window_r <= wbyte & `MASK_CONTROL_D;
        `IDX_IRQ_ENABLE: irq_enable_r <= wbyte & `MASK_IRQ;
        `IDX_DEBUG_CONTROL: debug_control_r <= {7'h00, wbyte[`BIT_RUN_WHILE_HALTED]};
        `IDX_COMMAND: command_r <= wbyte;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_b_prescale_r <= `RESET_BYTE;
      control_c_reference_r <= `RESET_BYTE;
      control_e_sample_time_r <= `RESET_BYTE;
      control_f_accumulate_r <= `RESET_BYTE;
      gain_amp_control_r <= `RESET_BYTE;
      positive_input_select_r <= `RESET_BYTE;
      negative_input_select_r <= `RESET_BYTE;
      temp_byte_r[0] <= `RESET_BYTE;
      temp_byte_r[1] <= `RESET_BYTE;
      temp_byte_r[2] <= `RESET_BYTE;
      window_low_threshold_r <= 16'h0000;
      window_high_threshold_r <= 16'h0000;
    end else if (wr_en) begin
      unique case (idx)
        `IDX_CONTROL_B_PRESCALE: control_b_prescale_r <= {4'h0, wbyte[3:0]};
        `IDX_CONTROL_C_REFERENCE: control_c_reference_r <= wbyte;
        `IDX_CONTROL_E_SAMPLE_TIME: control_e_sample_time_r <= wbyte;
        `IDX_CONTROL_F_ACCUMULATE: control_f_accumulate_r <= wbyte;
        `IDX_GAIN_AMP_CONTROL: gain_amp_control_r <= wbyte;
        `IDX_POSITIVE_INPUT_SELECT: positive_input_select_r <= wbyte;
        `IDX_NEGATIVE_INPUT_SELECT: negative_input_select_r <= wbyte;
        `IDX_TEMP_BYTE_0: temp_byte_r[0] <= wbyte;
        `IDX_TEMP_BYTE_1: temp_byte_r[1] <= wbyte;
        `IDX_TEMP_BYTE_2: temp_byte_r[2] <= wbyte;
        `IDX_WINDOW_LOW_THRESHOLD: window_low_threshold_r <= pwdata[15:0];
        `IDX_WINDOW_HIGH_THRESHOLD: window_high_threshold_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ======================================================
  // read mux, registered in the setup cycle
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (idx)
      `IDX_CONTROL_A: rd_val[7:0] = control_a_r;
      `IDX_CONTROL_B_PRESCALE: rd_val[7:0] = control_b_prescale_r;
      `IDX_CONTROL_C_REFERENCE: rd_val[7:0] = control_c_reference_r;
      `IDX_CONTROL_D_WINDOW: rd_val[7:0] = control_d_window_r;
      `IDX_IRQ_ENABLE: rd_val[7:0] = irq_enable_r;
      `IDX_IRQ_FLAG: rd_val[7:0] = irq_flag_r;
      `IDX_STATUS: rd_val[`BIT_BUSY] = busy;
      `IDX_DEBUG_CONTROL: rd_val[7:0] = debug_control_r;
      `IDX_CONTROL_E_SAMPLE_TIME: rd_val[7:0] = control_e_sample_time_r;
      `IDX_CONTROL_F_ACCUMULATE: rd_val[7:0] = control_f_accumulate_r;
      `IDX_COMMAND: rd_val[7:0] = command_r;
      `IDX_GAIN_AMP_CONTROL: rd_val[7:0] = gain_amp_control_r;
      `IDX_POSITIVE_INPUT_SELECT: rd_val[7:0] = positive_input_select_r;
      `IDX_NEGATIVE_INPUT_SELECT: rd_val[7:0] = negative_input_select_r;
      `IDX_RESULT: rd_val = result_r;
      `IDX_SAMPLE: rd_val[15:0] = sample_r;
      `IDX_TEMP_BYTE_0: rd_val[7:0] = temp_byte_r[0];
      `IDX_TEMP_BYTE_1: rd_val[7:0] = temp_byte_r[1];
      `IDX_TEMP_BYTE_2: rd_val[7:0] = temp_byte_r[2];
      `IDX_WINDOW_LOW_THRESHOLD: rd_val[15:0] = window_low_threshold_r;
      `IDX_WINDOW_HIGH_THRESHOLD: rd_val[15:0] = window_high_threshold_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_phase) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_r <= !mapped;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r && psel && penable;
  assign pready = 1'b1;

endmodule // adc_irq_sleep_debug_regs

// ==== testbench/conv_ctl_assertions.sv ====
// property checker for the converter control shell
`timescale 1ns/1ns
module conv_ctl_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire conv_ctl_pkg::apb_word_type prdata,
  input wire logic pready,
  // system state
  input wire logic sleep_idle,
  input wire logic sleep_standby,
  input wire logic sleep_powerdown,
  input wire logic debug_halt,
  // converter core
  input wire logic conv_sample_done,
  input wire logic conv_result_done,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic analog_power_on,
  // interrupt requests
  input wire logic irq_error,
  input wire logic irq_sample_ready,
  input wire logic irq_result_ready
);
  import conv_ctl_pkg::*;
  // ======================================================
  // shadow state
  logic busy_r;
  logic [7:0] ctla_r;
  logic dbg_r;
  wire apb_wr = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
    end else if (conv_start) begin
      busy_r <= 1'b1;
    end else if (conv_result_done || conv_abort) begin
      busy_r <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctla_r <= 8'h00;
      dbg_r <= 1'b0;
    end else if (apb_wr && paddr == 8'h00) begin
      ctla_r <= pwdata[7:0] & 8'ha1;
    end else if (apb_wr && paddr == 8'h1c) begin
      dbg_r <= pwdata[0];
    end
  end
  // ======================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_no_restart: assert property (busy_r |-> !conv_start)
    else $error("start while busy");
  chk_pd_abort: assert property (busy_r && sleep_powerdown |-> conv_abort)
    else $error("no abort in power-down");
  chk_pd_nostart: assert property (sleep_powerdown |-> !conv_start)
    else $error("start in power-down");
  chk_sleep_finish: assert property (busy_r && (sleep_idle || sleep_standby) && !sleep_powerdown && ctla_r[0]
    |-> !conv_abort)
    else $error("abort in idle or standby");
  chk_stby_gate: assert property (sleep_standby && !ctla_r[7] |-> !conv_start)
    else $error("start in standby");
  chk_halt_gate: assert property (debug_halt && !dbg_r |-> !conv_start)
    else $error("start while halted");
  chk_err_hold: assert property (irq_error && !apb_wr |=> irq_error)
    else $error("error request dropped");
  chk_res_cause: assert property ($rose(irq_result_ready) |-> $past(conv_result_done) || $past(apb_wr))
    else $error("result request without cause");
  chk_samp_cause: assert property ($rose(irq_sample_ready) |-> $past(conv_sample_done) || $past(apb_wr))
    else $error("sample request without cause");
  chk_ctla_read: assert property (psel && penable && !pwrite && paddr == 8'h00 |-> prdata == {24'h0, ctla_r})
    else $error("control a readback");
  chk_keep_on: assert property (ctla_r[0] && ctla_r[5] && !sleep_powerdown |-> analog_power_on)
    else $error("analog power off");
  cover property (conv_start && sleep_standby);
  cover property (conv_abort);
  cover property (irq_error);
endmodule // conv_ctl_assertions

bind adc_irq_sleep_debug_regs conv_ctl_assertions i_chk (.*);

// ==== testbench/conv_core_model.sv ====
// behavioural model of the converter core
`timescale 1ns/1ns
module conv_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic [7:0] latency,
  input wire logic [15:0] sample_val,
  input wire logic [31:0] result_val,
  // results
  output logic conv_sample_done,
  output logic [15:0] conv_sample_data,
  output logic conv_result_done,
  output logic [31:0] conv_result_data
);
  logic [7:0] cnt_r;
  logic run_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (conv_start) begin
      run_r <= 1'b1;
      cnt_r <= latency;
    end else if (conv_abort || conv_result_done) begin
      run_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign conv_sample_done = run_r && cnt_r == 8'h00;
  assign conv_result_done = conv_sample_done;
  // data lines show no stale value outside the done cycle
  assign conv_sample_data = conv_sample_done ? sample_val : ~sample_val;
  assign conv_result_data = conv_result_done ? result_val : ~result_val;
endmodule // conv_core_model

// ==== testbench/tb_top.sv ====
// self-checking bench for the converter control shell
`timescale 1ns/1ns
`include "conv_ctl_defines.svh"
module tb_top;
  import conv_ctl_pkg::*;
  typedef struct {logic [5:0] idx; logic [31:0] wd; logic [31:0] rd; logic err;} row_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  apb_word_type prdata;
  logic pready, pslverr, s_done, r_done, conv_start, conv_abort, apwr, irq_e, irq_s, irq_r;
  logic idle = 1'b0, stby = 1'b0, pdown = 1'b0, halt = 1'b0, evt = 1'b0;
  logic [15:0] s_data;
  logic [31:0] r_data;
  logic [7:0] lat = 8'h04;
  logic [15:0] s_val = 16'h0123;
  logic [31:0] r_val = 32'h00ab0123;
  int fail_count = 0;
  int num_checks = 0;
  int starts = 0;
  int dones = 0;
  int s0;
  logic [31:0] rd;
  logic er;
  row_type rows [5];
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    starts <= starts + (conv_start === 1'b1);
    dones <= dones + (r_done === 1'b1);
  end
  adc_irq_sleep_debug_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_idle(idle), .sleep_standby(stby), .sleep_powerdown(pdown), .debug_halt(halt), .start_event(evt),
    .conv_sample_done(s_done), .conv_sample_data(s_data), .conv_result_done(r_done),
    .conv_result_data(r_data), .conv_start(conv_start), .conv_abort(conv_abort), .analog_power_on(apwr),
    .irq_error(irq_e), .irq_sample_ready(irq_s), .irq_result_ready(irq_r));
  conv_core_model i_core (.pclk(pclk), .presetn(presetn), .conv_start(conv_start), .conv_abort(conv_abort),
    .latency(lat), .sample_val(s_val), .result_val(r_val), .conv_sample_done(s_done),
    .conv_sample_data(s_data), .conv_result_done(r_done), .conv_result_data(r_data));
  // ======================================================
  // tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timeout();
    check(32'h0, 32'h1);
    summarize();
  endtask
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) timeout();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_done();
    int n = 0;
    int d = dones;
    while (dones == d && n < 300) begin
      n++;
      @(posedge pclk);
    end
    if (dones == d) timeout();
    repeat (2) @(posedge pclk);
  endtask
  task automatic pulse();
    evt <= 1'b1;
    repeat (2) @(posedge pclk);
    evt <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic drain();
    apb(1'b0, `IDX_SAMPLE, 32'h0);
    apb(1'b0, `IDX_RESULT, 32'h0);
    apb(1'b1, `IDX_IRQ_FLAG, 32'h3f);
  endtask
  function automatic logic win_exp(input logic [2:0] m, input logic [15:0] v);
    case (m)
      3'h1: return v < 16'h0100;
      3'h2: return v > 16'h0200;
      3'h3: return v > 16'h0100 && v < 16'h0200;
      3'h4: return v < 16'h0100 || v > 16'h0200;
      default: return 1'b0;
    endcase
  endfunction
  // ======================================================
  // sequence
  initial begin
    rows[0] = '{`IDX_CONTROL_A, 32'hff, 32'ha1, 1'b0};
    rows[1] = '{`IDX_CONTROL_D_WINDOW, 32'hff, 32'h0f, 1'b0};
    rows[2] = '{`IDX_IRQ_ENABLE, 32'hff, 32'h3f, 1'b0};
    rows[3] = '{`IDX_WINDOW_HIGH_THRESHOLD, 32'hffffffff, 32'hffff, 1'b0};
    rows[4] = '{6'h0e, 32'hff, 32'h0, 1'b1};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `IDX_CONTROL_A, 32'h0);
    check(rd, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd);
      apb(1'b0, rows[i].idx, 32'h0);
      check(rd, rows[i].rd);
      check({31'h0, er}, {31'h0, rows[i].err});
    end
    apb(1'b1, `IDX_IRQ_ENABLE, 32'h0);
    apb(1'b1, `IDX_CONTROL_D_WINDOW, 32'h0);
    apb(1'b1, `IDX_CONTROL_A, 32'h01);
    apb(1'b1, `IDX_COMMAND, 32'h1);
    wait_done();
    apb(1'b0, `IDX_IRQ_FLAG, 32'h0);
    check(rd, 32'h03);
    check({irq_e, irq_s, irq_r}, 32'h0);
    apb(1'b1, `IDX_IRQ_ENABLE, 32'h3b);
    check({irq_e, irq_s, irq_r}, 32'h3);
    apb(1'b1, `IDX_IRQ_FLAG, 32'h01);
    apb(1'b0, `IDX_IRQ_FLAG, 32'h0);
    check(rd, 32'h02);
    check({irq_e, irq_s, irq_r}, 32'h2);
    apb(1'b1, `IDX_COMMAND, 32'h1);
    wait_done();
    apb(1'b0, `IDX_IRQ_FLAG, 32'h0);
    check(rd, 32'h1b);
    check({irq_e, irq_s, irq_r}, 32'h7);
    apb(1'b0, `IDX_SAMPLE, 32'h0);
    check(rd, {16'h0, s_val});
    apb(1'b0, `IDX_RESULT, 32'h0);
    check(rd, r_val);
    apb(1'b1, `IDX_IRQ_FLAG, 32'h3f);
    check({irq_e, irq_s, irq_r}, 32'h0);
    lat <= 8'd40;
    s0 = starts;
    apb(1'b1, `IDX_COMMAND, 32'h1);
    apb(1'b1, `IDX_COMMAND, 32'h1);
    wait_done();
    apb(1'b0, `IDX_IRQ_FLAG, 32'h0);
    check(rd, 32'h23);
    check(starts - s0, 32'h1);
    drain();
    apb(1'b1, `IDX_COMMAND, 32'h1);
    pdown <= 1'b1;
    #1 check({31'h0, conv_abort}, 32'h1);
    s0 = dones;
    repeat (50) @(posedge pclk);
    check(dones - s0, 32'h0);
    pdown <= 1'b0;
    apb(1'b0, `IDX_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `IDX_COMMAND, 32'h1);
    idle <= 1'b1;
    wait_done();
    apb(1'b1, `IDX_COMMAND, 32'h2);
    s0 = starts;
    pulse();
    check(starts - s0, 32'h1);
    wait_done();
    idle <= 1'b0;
    stby <= 1'b1;
    s0 = starts;
    pulse();
    check(starts - s0, 32'h0);
    apb(1'b1, `IDX_CONTROL_A, 32'ha1);
    check({31'h0, apwr}, 32'h1);
    pulse();
    check(starts - s0, 32'h1);
    wait_done();
    stby <= 1'b0;
    apb(1'b1, `IDX_CONTROL_A, 32'h01);
    halt <= 1'b1;
    pulse();
    check(starts - s0, 32'h1);
    apb(1'b1, `IDX_DEBUG_CONTROL, 32'h1);
    pulse();
    check(starts - s0, 32'h2);
    wait_done();
    halt <= 1'b0;
    drain();
    lat <= 8'h04;
    apb(1'b1, `IDX_IRQ_ENABLE, 32'h04);
    apb(1'b1, `IDX_COMMAND, 32'h1);
    apb(1'b1, `IDX_WINDOW_LOW_THRESHOLD, 32'h0100);
    apb(1'b1, `IDX_WINDOW_HIGH_THRESHOLD, 32'h0200);
    for (int v = 0; v < 3; v++) begin
      for (int m = 0; m < 5; m++) begin
        s_val <= 16'h0050 + 16'(v) * 16'h0100;
        r_val <= 32'h00050 + 32'(v) * 32'h0100;
        apb(1'b1, `IDX_CONTROL_D_WINDOW, 32'(m));
        apb(1'b1, `IDX_COMMAND, 32'h1);
        wait_done();
        check({31'h0, irq_r}, {31'h0, win_exp(3'(m), s_val)});
        drain();
      end
    end
    s_val <= 16'h0050;
    r_val <= 32'h0150;
    apb(1'b1, `IDX_CONTROL_D_WINDOW, 32'h09);
    apb(1'b1, `IDX_COMMAND, 32'h1);
    wait_done();
    check({irq_s, irq_r}, 32'h2);
    summarize();
  end
endmodule // tb_top
